// ===== hdl/smk_security_mode.sv
// Security mode logic: key unlock, key update guard and access grants
`timescale 1ns/1ps
`default_nettype none
`include "smk_consts.svh"

module smk_security_mode
   import smk_pkg::*;
(
   // Clock, reset, enable
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        clk_en,
   // Command word writes from the host
   input  wire logic        cmd_wr,
   input  wire logic [15:0] cmd_data,
   input  wire logic        seal_req,
   // Key update requests
   input  wire logic        key_wr,
   input  wire logic [1:0]  key_wr_idx,
   input  wire logic [15:0] key_wr_data,
   output logic             key_wr_done,
   output logic             key_wr_err,
   // Status
   output logic             sealed_flag,
   output logic             full_access_flag,
   output logic [2:0]       mode_out,
   // Access grants
   output logic             gen_store_rd_en,
   output logic             gen_store_wr_en,
   output logic             info_rd_en,
   output logic             info_a_wr_en,
   output logic             info_bc_wr_en
);

   smk_mode_t   mode;
   smk_mode_t   next_mode;
   logic        pending;
   logic        next_pending;
   logic [63:0] key_words;
   logic [15:0] exp_k1;
   logic [15:0] exp_k0;
   logic        key_wr_ok;

   // Swap the two bytes of a key word
   function automatic logic [15:0] swap16(input logic [15:0] w);
      swap16 = {w[7:0], w[15:8]};
   endfunction

   // Unsealed and full access grant the same data access
   function automatic logic is_open(input smk_mode_t m);
      is_open = (m == SMK_UNSEALED) || (m == SMK_FULL);
   endfunction

   // Keys may only change in full access
   assign key_wr_ok = key_wr && (mode == SMK_FULL);

   smk_key_store u_keys (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .clk_en    (clk_en),
      .wr_en     (key_wr_ok),
      .wr_idx    (key_wr_idx),
      .wr_data   (key_wr_data),
      .key_words (key_words)
   );

   // Expected command words for the pair that leaves the present mode
   always_comb begin
      if (mode == SMK_SEALED) begin
         exp_k1 = swap16(key_words[16*`SMK_IDX_UNSEAL_K1 +: 16]);
         exp_k0 = swap16(key_words[16*`SMK_IDX_UNSEAL_K0 +: 16]);
      end else begin
         exp_k1 = swap16(key_words[16*`SMK_IDX_FULL_K1 +: 16]);
         exp_k0 = swap16(key_words[16*`SMK_IDX_FULL_K0 +: 16]);
      end
   end

   // Pair tracking and mode steps; full access has no further key to take
   always_comb begin
      next_mode    = mode;
      next_pending = pending;
      if (seal_req) begin
         next_mode    = SMK_SEALED;
         next_pending = 1'b0;
      end else if (cmd_wr && (mode != SMK_FULL)) begin
         if (pending) begin
            // Second word: complete the pair or drop it
            next_pending = 1'b0;
            if (cmd_data == exp_k0) begin
               case (mode)
                  SMK_SEALED:   next_mode = SMK_UNSEALED;
                  SMK_UNSEALED: next_mode = SMK_FULL;
                  default:      next_mode = mode;
               endcase
            end
         end else begin
            // Key 1 comes first
            next_pending = (cmd_data == exp_k1);
         end
      end
   end

   // Mode register; devices start sealed
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         mode <= SMK_SEALED;
      end else if (clk_en) begin
         mode <= next_mode;
      end
   end

   // Pending first key
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pending <= 1'b0;
      end else if (clk_en) begin
         pending <= next_pending;
      end
   end

   // Status flags follow the mode in the same cycle
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sealed_flag      <= 1'b1;
         full_access_flag <= 1'b1;
         mode_out         <= 3'h1;
      end else if (clk_en) begin
         sealed_flag      <= (next_mode == SMK_SEALED);
         full_access_flag <= (next_mode != SMK_FULL);
         mode_out         <= next_mode;
      end
   end

   // Access grants follow the mode in the same cycle
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         gen_store_rd_en <= 1'b0;
         gen_store_wr_en <= 1'b0;
         info_rd_en      <= 1'b1;
         info_a_wr_en    <= 1'b0;
         info_bc_wr_en   <= 1'b1;
      end else if (clk_en) begin
         gen_store_rd_en <= is_open(next_mode);
         gen_store_wr_en <= is_open(next_mode);
         info_rd_en      <= 1'b1;
         info_a_wr_en    <= is_open(next_mode);
         info_bc_wr_en   <= 1'b1;
      end
   end

   // Key update answer: one-cycle pulse, done or refused
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         key_wr_done <= 1'b0;
         key_wr_err  <= 1'b0;
      end else if (clk_en) begin
         key_wr_done <= key_wr_ok;
         key_wr_err  <= key_wr && !key_wr_ok;
      end
   end

   chk_unseal_pair: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      clk_en && !seal_req && cmd_wr && pending && mode == SMK_SEALED
         && cmd_data == exp_k0
      |=> mode == SMK_UNSEALED && !sealed_flag)
      else $error("unseal pair did not unseal");

   chk_full_pair: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      clk_en && !seal_req && cmd_wr && pending && mode == SMK_UNSEALED
         && cmd_data == exp_k0
      |=> mode == SMK_FULL && !full_access_flag)
      else $error("full-access pair did not grant full access");

   chk_pair_discard: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      clk_en && !seal_req && cmd_wr && pending && cmd_data != exp_k0
      |=> !pending && mode == $past(mode))
      else $error("bad second key word not discarded");

   chk_no_mode_skip: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      mode == SMK_SEALED |=> mode != SMK_FULL)
      else $error("sealed jumped straight to full access");

   chk_sealed_flags: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      mode == SMK_SEALED |-> sealed_flag && full_access_flag)
      else $error("sealed mode flags wrong");

   chk_key_guard: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      clk_en && key_wr && mode != SMK_FULL
      |=> key_wr_err && !key_wr_done ##1 !key_wr_done)
      else $error("key update accepted outside full access");

   chk_key_accept: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      clk_en && key_wr && mode == SMK_FULL |=> key_wr_done && !key_wr_err)
      else $error("key update refused in full access");

   chk_store_closed: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      mode == SMK_SEALED |-> !gen_store_rd_en && !gen_store_wr_en)
      else $error("general store open while sealed");

   chk_open_same: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      mode != SMK_SEALED
      |-> gen_store_rd_en && gen_store_wr_en && info_a_wr_en)
      else $error("open modes differ in data access");

   chk_block_a_ro: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      mode == SMK_SEALED |-> !info_a_wr_en && info_bc_wr_en && info_rd_en)
      else $error("sealed info block grants wrong");

endmodule
`default_nettype wire

// ===== hdl/smk_consts.svh
// Constants for the security mode key unlock block
`ifndef SMK_CONSTS_SVH
`define SMK_CONSTS_SVH

// Key store layout: word index of each stored key word
`define SMK_IDX_UNSEAL_K0 2'h0
`define SMK_IDX_UNSEAL_K1 2'h1
`define SMK_IDX_FULL_K0   2'h2
`define SMK_IDX_FULL_K1   2'h3

// Key word width and word count of the packed key bus
`define SMK_KEY_W         16
`define SMK_KEY_WORDS     4

// Reset values of the stored keys (key 0 is the upper half of the pair)
`define SMK_RST_UNSEAL_K0 16'h3672
`define SMK_RST_UNSEAL_K1 16'h0414
`define SMK_RST_FULL_K0   16'hFFFF
`define SMK_RST_FULL_K1   16'hFFFF

`endif

// ===== hdl/smk_pkg.sv
// Types shared by the security mode key unlock block
package smk_pkg;

   // Security modes, one-hot
   typedef enum logic [2:0] {
      SMK_SEALED   = 3'b001,
      SMK_UNSEALED = 3'b010,
      SMK_FULL     = 3'b100
   } smk_mode_t;

endpackage

// ===== hdl/smk_key_store.sv
// Small store holding the unseal and full-access key words
`timescale 1ns/1ps
`default_nettype none
`include "smk_consts.svh"

module smk_key_store
   import smk_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        clk_en,
   // Write port
   input  wire logic        wr_en,
   input  wire logic [1:0]  wr_idx,
   input  wire logic [15:0] wr_data,
   // Registered copy of all words, word i at bits 16*i+15:16*i
   output logic      [63:0] key_words
);

   logic [15:0] mem  [0:3];
   logic [15:0] rd_q [0:3];

   // One driver for the whole output bus, built from the per-word registers
   assign key_words = {rd_q[3], rd_q[2], rd_q[1], rd_q[0]};

   // Reset value of each stored word
   function automatic logic [15:0] smk_rst_word(input int idx);
      case (idx)
         0:       smk_rst_word = `SMK_RST_UNSEAL_K0;
         1:       smk_rst_word = `SMK_RST_UNSEAL_K1;
         2:       smk_rst_word = `SMK_RST_FULL_K0;
         default: smk_rst_word = `SMK_RST_FULL_K1;
      endcase
   endfunction

   genvar i;
   generate
      for (i = 0; i < `SMK_KEY_WORDS; i++) begin : g_word
         // Storage word; written only when the caller allows it
         always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
               mem[i] <= smk_rst_word(i);
            end else if (clk_en && wr_en && (wr_idx == 2'(i))) begin
               mem[i] <= wr_data;
            end
         end

         // Read data out of a register, so a new key acts one cycle late
         always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
               rd_q[i] <= smk_rst_word(i);
            end else if (clk_en) begin
               rd_q[i] <= mem[i];
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire

// ===== dv/smk_host_model.sv
// Host model that presents key pairs on the command word port
`timescale 1ns/1ps
`default_nettype none

module smk_host_model (
   // Clock
   input  wire logic        clk_sys,
   // Command word writes
   output logic             cmd_wr,
   output logic [15:0]      cmd_data
);
   // Idle state at time zero, no write pending
   initial begin
      cmd_wr   = 1'b0;
      cmd_data = 16'h0000;
   end

   // Send a pair given in stored form; caller stands just after an edge
   task automatic send_pair(input logic [15:0] k1, input logic [15:0] k0);
      cmd_wr   = 1'b1;
      cmd_data = {k1[7:0], k1[15:8]};  // Key 1 first, bytes swapped
      @(posedge clk_sys);
      #1;
      cmd_data = {k0[7:0], k0[15:8]};  // Back to back, nothing between
      @(posedge clk_sys);
      #1;
      cmd_wr   = 1'b0;
      // Released bus shows a changed pattern, never the stale word
      cmd_data = ~cmd_data;
      // Let one edge pass so a following call never re-raises the strobe
      @(posedge clk_sys);
      #1;
   endtask
endmodule

`default_nettype wire

// ===== dv/smk_security_mode_bench.sv
// Self-checking bench for the security mode key unlock block
`timescale 1ns/1ps
`default_nettype none

module smk_security_mode_bench
   import smk_pkg::*;
();
   logic        clk_sys     = 1'b0;
   logic        rst_n       = 1'b0;
   logic        clk_en      = 1'b1;
   logic        seal_req    = 1'b0;
   logic        key_wr      = 1'b0;
   logic [1:0]  key_wr_idx  = 2'h0;
   logic [15:0] key_wr_data = 16'h0000;
   wire logic        cmd_wr, key_wr_done, key_wr_err, sealed_flag;
   wire logic        full_access_flag, gen_rd, gen_wr, info_rd, info_a;
   wire logic        info_bc;
   wire logic [15:0] cmd_data;
   wire logic [2:0]  mode_out;
   int          n_fail      = 0;
   int          tests_run   = 0;

   // 25 MHz system clock
   always #20 clk_sys = ~clk_sys;

   smk_host_model host (.clk_sys(clk_sys), .cmd_wr(cmd_wr),
      .cmd_data(cmd_data));

   smk_security_mode dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
      .cmd_wr(cmd_wr), .cmd_data(cmd_data), .seal_req(seal_req),
      .key_wr(key_wr), .key_wr_idx(key_wr_idx), .key_wr_data(key_wr_data),
      .key_wr_done(key_wr_done), .key_wr_err(key_wr_err),
      .sealed_flag(sealed_flag), .full_access_flag(full_access_flag),
      .mode_out(mode_out), .gen_store_rd_en(gen_rd), .gen_store_wr_en(gen_wr),
      .info_rd_en(info_rd), .info_a_wr_en(info_a), .info_bc_wr_en(info_bc));

   // Compare one value, case equality so unknowns never match
   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Step to just after the next edge, where outputs have settled
   task automatic tick();
      @(posedge clk_sys);
      #1;
   endtask

   // Mode, flags and access grants together
   task automatic state(smk_mode_t m, logic s, logic f, logic g, logic a);
      check("mode_out", mode_out, m);
      check("sealed_flag", sealed_flag, s);
      check("full_access_flag", full_access_flag, f);
      check("gen_store_rd_en", gen_rd, g);
      check("gen_store_wr_en", gen_wr, g);
      check("info_rd_en", info_rd, 1'b1);
      check("info_a_wr_en", info_a, a);
      check("info_bc_wr_en", info_bc, 1'b1);
   endtask

   // Seal request pulse; state checked one edge after it is taken
   task automatic seal();
      seal_req = 1'b1;
      tick();
      seal_req = 1'b0;
      tick();
      state(SMK_SEALED, 1'b1, 1'b1, 1'b0, 1'b0);
   endtask

   // One key word write, answered by a one-cycle done or error pulse
   task automatic key_put(logic [1:0] i, logic [15:0] d, logic ok);
      key_wr      = 1'b1;
      key_wr_idx  = i;
      key_wr_data = d;
      tick();
      key_wr      = 1'b0;
      key_wr_data = ~d;
      check("key_wr_done", key_wr_done, ok);
      check("key_wr_err", key_wr_err, !ok);
      tick();
      check("key_wr_done low", key_wr_done, 1'b0);
   endtask

   // Wrong order, foreign pair and a bad second word leave it sealed
   task automatic t_sealed_refusals();
      key_put(2'h0, 16'h1111, 1'b0);
      host.send_pair(16'h3672, 16'h0414);
      state(SMK_SEALED, 1'b1, 1'b1, 1'b0, 1'b0);
      seal();
      host.send_pair(16'hFFFF, 16'hFFFF);
      state(SMK_SEALED, 1'b1, 1'b1, 1'b0, 1'b0);
      host.send_pair(16'h0414, 16'h1234);
      state(SMK_SEALED, 1'b1, 1'b1, 1'b0, 1'b0);
   endtask

   // Unseal with default key, refuse key write, then enter full access
   task automatic t_unseal_full();
      host.send_pair(16'h0414, 16'h3672);
      state(SMK_UNSEALED, 1'b0, 1'b1, 1'b1, 1'b1);
      key_put(2'h2, 16'h0000, 1'b0);
      host.send_pair(16'hFFFF, 16'hFFFF);
      state(SMK_FULL, 1'b0, 1'b0, 1'b1, 1'b1);
   endtask

   // New unseal key replaces the old one only after full access
   task automatic t_rekey();
      key_put(2'h0, 16'h5678, 1'b1);
      key_put(2'h1, 16'h1234, 1'b1);
      seal();
      host.send_pair(16'h0414, 16'h3672);
      state(SMK_SEALED, 1'b1, 1'b1, 1'b0, 1'b0);
      host.send_pair(16'h1234, 16'h5678);
      state(SMK_UNSEALED, 1'b0, 1'b1, 1'b1, 1'b1);
   endtask

   // Frozen enable holds the mode; full access ignores command words
   task automatic t_freeze_full();
      clk_en = 1'b0;
      host.send_pair(16'hFFFF, 16'hFFFF);
      state(SMK_UNSEALED, 1'b0, 1'b1, 1'b1, 1'b1);
      clk_en = 1'b1;
      host.send_pair(16'hFFFF, 16'hFFFF);
      state(SMK_FULL, 1'b0, 1'b0, 1'b1, 1'b1);
      host.send_pair(16'h1234, 16'h5678);
      state(SMK_FULL, 1'b0, 1'b0, 1'b1, 1'b1);
      key_put(2'h3, 16'hABCD, 1'b1);
   endtask

   // Print counts and verdict, then end the run
   task automatic report_and_stop();
      $display("Counts: compared %0d failed %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Main sequence: reset for 8 cycles, then the scenarios
   initial begin
      repeat (8) @(posedge clk_sys);
      #1;
      rst_n = 1'b1;
      tick();
      state(SMK_SEALED, 1'b1, 1'b1, 1'b0, 1'b0);
      t_sealed_refusals();
      t_unseal_full();
      t_rekey();
      t_freeze_full();
      report_and_stop();
   end

   // Watchdog: the run needs about 53 cycles, this allows 2500
   initial begin
      #100000;
      n_fail++;
      report_and_stop();
   end
endmodule

`default_nettype wire
